//--- hdl/cpr_pkg.sv
// Package with register map, field positions and reset values for the result readout
package cpr_pkg;

  // ==========================================================================
  // Register offsets (byte addresses on the serial register port)
  localparam logic [7:0] CPR_ADDR_PART_NUMBER_CODE = 8'h12;
  localparam logic [7:0] CPR_ADDR_DEVICE_STATUS    = 8'h13;
  localparam logic [7:0] CPR_ADDR_CLEAR_COUNT_LOW  = 8'h14;
  localparam logic [7:0] CPR_ADDR_CLEAR_COUNT_HIGH = 8'h15;
  localparam logic [7:0] CPR_ADDR_RED_COUNT_LOW    = 8'h16;
  localparam logic [7:0] CPR_ADDR_RED_COUNT_HIGH   = 8'h17;
  localparam logic [7:0] CPR_ADDR_GREEN_COUNT_LOW  = 8'h18;
  localparam logic [7:0] CPR_ADDR_GREEN_COUNT_HIGH = 8'h19;
  localparam logic [7:0] CPR_ADDR_BLUE_COUNT_LOW   = 8'h1A;
  localparam logic [7:0] CPR_ADDR_BLUE_COUNT_HIGH  = 8'h1B;
  localparam logic [7:0] CPR_ADDR_PROX_COUNT_LOW   = 8'h1C;
  localparam logic [7:0] CPR_ADDR_PROX_COUNT_HIGH  = 8'h1D;

  // ==========================================================================
  // Status byte field positions
  localparam int CPR_STAT_COLOR_OK_BIT  = 0;
  localparam int CPR_STAT_PROX_OK_BIT   = 1;
  localparam int CPR_STAT_COLOR_IRQ_BIT = 4;
  localparam int CPR_STAT_PROX_IRQ_BIT  = 5;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  CPR_RST_BYTE  = 8'h00;
  localparam logic [15:0] CPR_RST_COUNT = 16'h0000;
  localparam logic        CPR_RST_FLAG  = 1'b0;

  // Part code default, value arbitrary
  localparam logic [7:0] CPR_PART_CODE_DEFAULT = 8'hA5;

endpackage

//--- hdl/cpr_valid_flag.sv
// Sticky valid flag: set by a completion pulse, cleared when its function is disabled
`timescale 1ns/1ps
module cpr_valid_flag
  import cpr_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  // Control
  input  wire logic enable_i,
  input  wire logic done_i,
  // Flag
  output logic      flag_o
);

  logic flag_r;
  logic flag_nxt;

  // ==========================================================================
  // Next value: a completion in the same cycle as enable wins, so no cycle is lost
  always_comb begin
    flag_nxt = flag_r;
    if (!enable_i) begin
      flag_nxt = 1'b0;
    end
    if (enable_i && done_i) begin
      flag_nxt = 1'b1;
    end
  end

  // Register
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      flag_r <= CPR_RST_FLAG;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flag_o = flag_r;

endmodule

//--- hdl/cpr_result_readout.sv
// Read-only result and status register group of the colour and proximity sensor
//
// What this block does
// RULE_01 - Eight-bit part number register, read only.
// RULE_02 - Status byte at 0x13, read only.
// RULE_03 - Status bit 5 proximity interrupt, bit 4 colour interrupt; 7:6, 3:2 reserved.
// RULE_04 - Status bit 0 sets when colour integration completes.
// RULE_05 - Status bit 1 sets when a cycle completes after colour enable.
// RULE_06 - Clear, red, green, blue counts at 0x14-0x1B, low byte first.
// RULE_07 - Proximity count low at 0x1C, high at 0x1D.
// RULE_08 - Reading a low byte latches that count's high byte into shadow.
// RULE_09 - Shadowed high byte stays consistent despite later count updates.
// RULE_10 - Host should read each count as one two-byte word read.
// RULE_11 - Writes have no effect; only low-byte reads change the shadow.
`timescale 1ns/1ps
module cpr_result_readout
  import cpr_pkg::*;
#(
  parameter logic [7:0] PART_CODE = cpr_pkg::CPR_PART_CODE_DEFAULT  // Value arbitrary
)
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  // Register port from the serial command decoder
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic [7:0]       reg_rdata_o,
  output logic             reg_rvalid_o,
  // Measurement engine results
  input  wire logic        color_enable_bit_i,
  input  wire logic        color_done_i,
  input  wire logic        prox_done_i,
  input  wire logic [15:0] clear_count_i,
  input  wire logic [15:0] red_count_i,
  input  wire logic [15:0] green_count_i,
  input  wire logic [15:0] blue_count_i,
  input  wire logic [15:0] prox_count_i,
  input  wire logic        prox_irq_flag_i,
  input  wire logic        color_irq_flag_i
);

  // ==========================================================================
  // Declarations
  logic [15:0] clear_r,  clear_nxt;
  logic [15:0] red_r,    red_nxt;
  logic [15:0] green_r,  green_nxt;
  logic [15:0] blue_r,   blue_nxt;
  logic [15:0] prox_r,   prox_nxt;
  logic [7:0]  shadow_r, shadow_nxt;
  logic [7:0]  rdata_r,  rdata_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic        color_result_ok;
  logic        prox_result_ok;
  logic [7:0]  status_byte;
  logic        rd_part;
  logic        rd_status;
  logic        rd_low;
  logic        rd_high;

  // Pick the 16-bit count whose low or high byte sits at this address
  // Any other address gives zero; callers decode the address before trusting
  // the result, so the default never reaches the read data register.
  function automatic logic [15:0] count_at(input logic [7:0] addr,
                                           input logic [15:0] c, input logic [15:0] r,
                                           input logic [15:0] g, input logic [15:0] b,
                                           input logic [15:0] p);
    logic [15:0] v;
    v = 16'h0000;
    if (addr == CPR_ADDR_CLEAR_COUNT_LOW || addr == CPR_ADDR_CLEAR_COUNT_HIGH) begin
      v = c;
    end else if (addr == CPR_ADDR_RED_COUNT_LOW || addr == CPR_ADDR_RED_COUNT_HIGH) begin
      v = r;
    end else if (addr == CPR_ADDR_GREEN_COUNT_LOW || addr == CPR_ADDR_GREEN_COUNT_HIGH) begin
      v = g;
    end else if (addr == CPR_ADDR_BLUE_COUNT_LOW || addr == CPR_ADDR_BLUE_COUNT_HIGH) begin
      v = b;
    end else if (addr == CPR_ADDR_PROX_COUNT_LOW || addr == CPR_ADDR_PROX_COUNT_HIGH) begin
      v = p;
    end
    return v;
  endfunction

  // True for any low-byte address of a count
  function automatic logic is_low_addr(input logic [7:0] addr);
    return (addr == CPR_ADDR_CLEAR_COUNT_LOW) || (addr == CPR_ADDR_RED_COUNT_LOW) ||
           (addr == CPR_ADDR_GREEN_COUNT_LOW) || (addr == CPR_ADDR_BLUE_COUNT_LOW) ||
           (addr == CPR_ADDR_PROX_COUNT_LOW);
  endfunction

  // True for any high-byte address of a count
  function automatic logic is_high_addr(input logic [7:0] addr);
    return (addr == CPR_ADDR_CLEAR_COUNT_HIGH) || (addr == CPR_ADDR_RED_COUNT_HIGH) ||
           (addr == CPR_ADDR_GREEN_COUNT_HIGH) || (addr == CPR_ADDR_BLUE_COUNT_HIGH) ||
           (addr == CPR_ADDR_PROX_COUNT_HIGH);
  endfunction

  // ==========================================================================
  // Valid flags
  // Both flags share one enable so that dropping colour enable clears them
  // together; after a restart the host never sees a stale valid bit.
  cpr_valid_flag u_color_ok (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .enable_i  (color_enable_bit_i),
    .done_i    (color_done_i),
    .flag_o    (color_result_ok)
  );  // see RULE_04

  // Proximity valid also tracks completions since colour enable was raised
  cpr_valid_flag u_prox_ok (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .enable_i  (color_enable_bit_i),
    .done_i    (prox_done_i),
    .flag_o    (prox_result_ok)
  );  // see RULE_05

  // Status byte, reserved bits read zero
  // The interrupt inputs are shown as they stand at the read edge; they are
  // latched by the interrupt logic outside, so no second copy is kept here.
  always_comb begin
    status_byte                         = CPR_RST_BYTE;  // see RULE_03
    status_byte[CPR_STAT_PROX_IRQ_BIT]  = prox_irq_flag_i;  // see RULE_03
    status_byte[CPR_STAT_COLOR_IRQ_BIT] = color_irq_flag_i;  // see RULE_03
    status_byte[CPR_STAT_PROX_OK_BIT]   = prox_result_ok;  // see RULE_05
    status_byte[CPR_STAT_COLOR_OK_BIT]  = color_result_ok;  // see RULE_04
  end

  // ==========================================================================
  // Result capture: each count updates when its measurement completes
  // A new result overwrites the old one; only the shadow keeps older data.
  always_comb begin
    clear_nxt = clear_r;
    red_nxt   = red_r;
    green_nxt = green_r;
    blue_nxt  = blue_r;
    prox_nxt  = prox_r;
    if (color_done_i) begin
      clear_nxt = clear_count_i;  // see RULE_06
      red_nxt   = red_count_i;
      green_nxt = green_count_i;
      blue_nxt  = blue_count_i;
    end
    if (prox_done_i) begin
      prox_nxt = prox_count_i;  // see RULE_07
    end
  end

  // Register the counts; reset clears every result to zero
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      clear_r <= CPR_RST_COUNT;
      red_r   <= CPR_RST_COUNT;
      green_r <= CPR_RST_COUNT;
      blue_r  <= CPR_RST_COUNT;
      prox_r  <= CPR_RST_COUNT;
    end else begin
      clear_r <= clear_nxt;
      red_r   <= red_nxt;
      green_r <= green_nxt;
      blue_r  <= blue_nxt;
      prox_r  <= prox_nxt;
    end
  end

  // ==========================================================================
  // Read decode
  // Every select is qualified by the read strobe, so a write to any of these
  // addresses cannot reach the shadow latch or the read data register.
  assign rd_part   = reg_rd_i && (reg_addr_i == CPR_ADDR_PART_NUMBER_CODE);  // see RULE_01
  assign rd_status = reg_rd_i && (reg_addr_i == CPR_ADDR_DEVICE_STATUS);  // see RULE_02
  assign rd_low    = reg_rd_i && is_low_addr(reg_addr_i);  // see RULE_08
  assign rd_high   = reg_rd_i && is_high_addr(reg_addr_i);  // see RULE_09

  // ==========================================================================
  // Read path and shadow latch
  // A low-byte read samples the live count, so the high half comes from the same
  // sample even if a new result lands before the high-byte read.
  always_comb begin
    logic [15:0] cnt;
    cnt        = count_at(reg_addr_i, clear_r, red_r, green_r, blue_r, prox_r);
    shadow_nxt = shadow_r;
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    // Writes are ignored entirely: reg_wr_i and reg_wdata_i steer nothing
    if (reg_rd_i) begin  // see RULE_11
      rvalid_nxt = 1'b1;
      if (rd_part) begin
        rdata_nxt = PART_CODE;  // see RULE_01
      end else if (rd_status) begin
        rdata_nxt = status_byte;  // see RULE_02
      end else if (rd_low) begin
        rdata_nxt  = cnt[7:0];  // see RULE_06
        shadow_nxt = cnt[15:8];  // see RULE_08
      end else if (rd_high) begin
        rdata_nxt = shadow_r;  // see RULE_09
      end else begin
        rdata_nxt = CPR_RST_BYTE;  // Unmapped here: read as zero
      end
    end
  end

  // Register the read side; a high read before any low read returns zero
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      shadow_r <= CPR_RST_BYTE;
      rdata_r  <= CPR_RST_BYTE;
      rvalid_r <= 1'b0;
    end else begin
      shadow_r <= shadow_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata_o  = rdata_r;
  assign reg_rvalid_o = rvalid_r;

endmodule

//--- testbench/cpr_result_readout_chk.sv
// Checker for the result readout register port
`timescale 1ns/1ps
module cpr_result_readout_chk
  import cpr_pkg::*;
#(
  parameter logic [7:0] PART_CODE = 8'h00
)
(
  // Clock, reset and register port
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_rd_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_rdata_o,
  input  wire logic       reg_rvalid_o,
  // Status sources
  input  wire logic       color_enable_bit_i,
  input  wire logic       prox_irq_flag_i,
  input  wire logic       color_irq_flag_i
);
  // ==========================================================================
  // Register port checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read got no answer");
  a_answer_once: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("answer without read");
  a_part_code: assert property (reg_rd_i && reg_addr_i == CPR_ADDR_PART_NUMBER_CODE
    |=> reg_rdata_o == PART_CODE) else $error("part code wrong");
  a_status_rsvd: assert property (reg_rd_i && reg_addr_i == CPR_ADDR_DEVICE_STATUS
    |=> reg_rdata_o[7:6] == 2'b00 && reg_rdata_o[3:2] == 2'b00) else $error("reserved set");
  a_status_irq: assert property (reg_rd_i && reg_addr_i == CPR_ADDR_DEVICE_STATUS
    |=> reg_rdata_o[5:4] == {$past(prox_irq_flag_i), $past(color_irq_flag_i)})
    else $error("irq bits wrong");
  // Valid flags cannot be set while colour enable has been low for two edges
  a_valid_clear: assert property (reg_rd_i && reg_addr_i == CPR_ADDR_DEVICE_STATUS
    && !color_enable_bit_i && $past(!color_enable_bit_i) |=> reg_rdata_o[1:0] == 2'b00)
    else $error("valid flags set");
  a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved");
  a_write_silent: assert property (reg_wr_i && !reg_rd_i ##1 !reg_rd_i
    |=> !reg_rvalid_o && $stable(reg_rdata_o)) else $error("write had effect");
endmodule
bind cpr_result_readout cpr_result_readout_chk #(.PART_CODE(PART_CODE)) i_chk (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
  .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .color_enable_bit_i(color_enable_bit_i), .prox_irq_flag_i(prox_irq_flag_i),
  .color_irq_flag_i(color_irq_flag_i));

//--- testbench/cpr_host_model.sv
// Host model issuing byte reads and writes on the register port
`timescale 1ns/1ps
module cpr_host_model (
  // Clock
  input  wire logic       clk_sys_i,
  // Register port
  output logic [7:0]      reg_addr_o,
  output logic            reg_rd_o,
  output logic            reg_wr_o,
  output logic [7:0]      reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i
);
  // Idle port; released lines show inverted data so stale values never pass as fresh
  initial begin
    reg_addr_o = 8'h00;
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // Read n bytes back to back from a upward; n of 2 is the word read
  task automatic read(input logic [7:0] a, input int n, output logic [15:0] d, output logic ok);
    d = 16'h0000;
    ok = 1'b1;
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    // Byte i is taken at loop edge i; its answer stands until edge i + 1
    for (int i = 0; i <= n; i++) begin
      @(posedge clk_sys_i);
      if (i > 0) begin
        if (reg_rvalid_i !== 1'b1) ok = 1'b0;
        d[8*(i-1) +: 8] = reg_rdata_i;
      end
      if (i + 1 < n) reg_addr_o <= a + 8'(i + 1);
      else if (i + 1 == n) begin
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
      end
    end
  endtask
  // Single write cycle
  task automatic write(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= v;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~v;
  endtask
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the result readout
`timescale 1ns/1ps
module tb_top;
  logic        clk_sys_i, reset_i, wr, rd, en, cdone, pdone, pirq, cirq, rvalid, ok;
  logic [7:0]  addr, wdata, rdata;
  logic [15:0] cnt [5];
  logic [15:0] d;
  int          bad_count, comparisons;
  logic [31:0] rows [10] = '{32'h12_01_005C, 32'h13_01_0033, 32'h14_02_C1C0, 32'h16_02_A2A1,
    32'h18_02_9392, 32'h1A_02_8483, 32'h1C_02_7574, 32'h11_01_0000, 32'h1E_01_0000, 32'hFF_01_0000};
  // ==========================================================================
  // Design and host
  cpr_result_readout #(.PART_CODE(8'h5C)) i_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .color_enable_bit_i(en), .color_done_i(cdone), .prox_done_i(pdone),
    .clear_count_i(cnt[0]), .red_count_i(cnt[1]), .green_count_i(cnt[2]),
    .blue_count_i(cnt[3]), .prox_count_i(cnt[4]), .prox_irq_flag_i(pirq),
    .color_irq_flag_i(cirq));
  cpr_host_model i_host (.clk_sys_i(clk_sys_i), .reg_addr_o(addr), .reg_rd_o(rd),
    .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
  // Clock
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // Compare and count
  task automatic rd_chk(input string nm, input logic [7:0] a, input int n, input logic [15:0] e);
    i_host.read(a, n, d, ok);
    comparisons++;
    if (ok !== 1'b1 || d !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h answer %b", nm, e, d, ok);
    end
  endtask
  // One completion pulse that also loads a new count
  task automatic pulse(input logic c, input logic p, input int k, input logic [15:0] v);
    @(posedge clk_sys_i);
    cdone <= c;
    pdone <= p;
    cnt[k] <= v;
    @(posedge clk_sys_i);
    cdone <= 1'b0;
    pdone <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence
  initial begin
    {reset_i, en, pirq, cirq, cdone, pdone} = 6'b111100;
    cnt = '{16'hC1C0, 16'hA2A1, 16'h9392, 16'h8483, 16'h7574};
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    pulse(1'b1, 1'b1, 0, 16'hC1C0);
    foreach (rows[i]) rd_chk("table", rows[i][31:24], rows[i][23:16], rows[i][15:0]);
    rd_chk("clear low", 8'h14, 1, 16'h00C0);
    pulse(1'b1, 1'b0, 0, 16'h5E5D);
    rd_chk("clear high kept", 8'h15, 1, 16'h00C1);
    rd_chk("prox low", 8'h1C, 1, 16'h0074);
    rd_chk("shared shadow", 8'h1B, 1, 16'h0075);
    i_host.write(8'h1D, 8'h00);
    i_host.write(8'h12, 8'hFF);
    rd_chk("high after write", 8'h1D, 1, 16'h0075);
    rd_chk("part after write", 8'h12, 1, 16'h005C);
    @(posedge clk_sys_i);
    {en, pirq, cirq} <= 3'b000;
    pulse(1'b1, 1'b1, 4, 16'h0102);
    rd_chk("status disabled", 8'h13, 1, 16'h0000);
    en <= 1'b1;
    pulse(1'b1, 1'b0, 0, 16'h5E5D);
    rd_chk("status colour", 8'h13, 1, 16'h0001);
    cirq <= 1'b1;
    pulse(1'b0, 1'b1, 4, 16'h0102);
    rd_chk("status both", 8'h13, 1, 16'h0013);
    rd_chk("new prox word", 8'h1C, 2, 16'h0102);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd_chk("word after reset", 8'h14, 2, 16'h0000);
    rd_chk("status after reset", 8'h13, 1, 16'h0010);
    print_verdict;
  end
endmodule
